// ### rtl/prs_resampler.sv
// What this block does
// - Polyphase filter: 32 phases of 6 taps
// - NCO picks output instants, any ratio from one to four
// - Decimation factor limited to one through four
// - Two halfbands give interpolation by two or four
// - One stage uses 23-tap; both chain 23 then 15
// - Seven multiplies long, five multiplies short
// - Halfbands share decimating halfband coefficient sets
// - Three low control bits select configuration
// - Control bit three bypasses polyphase filter
// - Extra data-ready pulses spaced by bits 4-11
// - Output buffer written one sample per clock
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module prs_resampler
	import prs_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [PRS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	// AXI4-Lite write response
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	output logic [1:0]                 s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	input  wire logic [PRS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	// AXI4-Lite read data
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	// Scaled samples from the gain stage
	input  wire prs_stream_type        in_sample,
	output logic                       in_ready,
	// Samples and data-ready strobe to the output formatter
	output prs_stream_type             out_sample
);

	// ************************************************************
	// State
	// ************************************************************
	// One record holds every flop, so the reset value and the
	// next-state copy can never cover different sets.
	typedef struct packed {
		logic [31:0]                          cfg;
		logic [31:0]                          step;
		logic                                 aw_got;
		logic                                 w_got;
		logic [PRS_ADDR_W-1:0]                aw_addr;
		logic [31:0]                          w_data;
		logic [3:0]                           w_strb;
		logic                                 bvalid;
		logic [1:0]                           bresp;
		logic                                 rvalid;
		logic [31:0]                          rdata;
		logic [1:0]                           rresp;
		prs_rs_state_type                     st;
		logic [PRS_TAPS-1:0][PRS_DATA_W-1:0]  hist;
		logic [PRS_NCO_W-1:0]                 nco;
		logic [PRS_PHASE_W-1:0]               phase;
		logic [PRS_TAP_W-1:0]                 tap;
		logic [39:0]                          mac;
		logic [PRS_DATA_W-1:0]                rs_data;
		logic [PRS_DELAY_W-1:0]               gap;
		logic                                 out_valid;
		logic [PRS_DATA_W-1:0]                out_data;
		logic [15:0]                          out_count;
	} prs_top_state_type;

	prs_top_state_type r;
	prs_top_state_type next_r;

	// Decoded configuration and inter-stage handshakes.
	prs_mode_type         mode;
	logic                 bypass;
	logic                 interpolating;
	logic [PRS_NCO_W-1:0] step_eff;
	prs_stream_type       rs_out;
	prs_stream_type       hb1_in;
	prs_stream_type       hb1_out;
	prs_stream_type       hb2_in;
	prs_stream_type       hb2_out;
	prs_stream_type       pace_src;
	logic                 rs_ready;
	logic                 hb1_in_ready;
	logic                 hb1_out_ready;
	logic                 hb2_in_ready;
	logic                 pace_ready;

	// ************************************************************
	// Configuration decode
	// ************************************************************
	assign mode          = prs_decode_mode(r.cfg[PRS_MODE_LSB +: PRS_MODE_W]);
	assign bypass        = r.cfg[PRS_BYPASS_BIT];
	assign interpolating = (mode != PRS_MODE_RS_ONLY);

	// The step is the input-to-output period in 1/65536 input samples,
	// clamped so the decimation factor stays between one and four.
	always_comb
	begin
		if (r.step < 32'(PRS_NCO_ONE))
			step_eff = PRS_NCO_ONE;
		else if (r.step > 32'(PRS_NCO_MAX))
			step_eff = PRS_NCO_MAX;
		else
			step_eff = r.step[PRS_NCO_W-1:0];
	end

	// ************************************************************
	// Stream routing between the stages
	// ************************************************************
	// Changing the mode while samples are in flight may drop or
	// duplicate one sample; software should change it when idle.
	assign rs_out.valid  = (r.st == PRS_RS_OUT);
	assign rs_out.data   = r.rs_data;
	assign hb1_in.valid  = rs_out.valid && interpolating;
	assign hb1_in.data   = rs_out.data;
	assign hb2_in.valid  = hb1_out.valid && (mode == PRS_MODE_TWO_HB);
	assign hb2_in.data   = hb1_out.data;
	assign rs_ready      = interpolating ? hb1_in_ready : pace_ready;
	assign hb1_out_ready = (mode == PRS_MODE_TWO_HB) ? hb2_in_ready : pace_ready;
	assign in_ready      = (r.st == PRS_RS_IDLE);
	assign pace_ready    = (r.gap == '0);

	always_comb
	begin
		if (mode == PRS_MODE_ONE_HB)
			pace_src = hb1_out;
		else if (mode == PRS_MODE_TWO_HB)
			pace_src = hb2_out;
		else
			pace_src = rs_out;
	end

	// ************************************************************
	// Interpolating halfbands
	// ************************************************************
	// The 23-tap stage always comes first; the 15-tap stage runs at
	// twice its rate and is used only for interpolation by four.
	prs_halfband_interp #(
		.NMUL     (PRS_HB_LONG_MULS),
		.LONG_SET (1'b1)
	) u_hb_long (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.in_sample  (hb1_in),
		.in_ready   (hb1_in_ready),
		.out_sample (hb1_out),
		.out_ready  (hb1_out_ready)
	);

	prs_halfband_interp #(
		.NMUL     (PRS_HB_SHORT_MULS),
		.LONG_SET (1'b0)
	) u_hb_short (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.in_sample  (hb2_in),
		.in_ready   (hb2_in_ready),
		.out_sample (hb2_out),
		.out_ready  (pace_ready)
	);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb
	begin
		logic [PRS_NCO_W-1:0]            acc;
		logic signed [2*PRS_DATA_W:0]    prod;
		acc    = '0;
		prod   = '0;
		next_r = r;

		// Write channel: address and data are taken in either order.
		if (s_axi_awvalid && !r.aw_got)
		begin
			next_r.aw_got  = 1'b1;
			next_r.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !r.w_got)
		begin
			next_r.w_got  = 1'b1;
			next_r.w_data = s_axi_wdata;
			next_r.w_strb = s_axi_wstrb;
		end
		// A status write is dropped; an unmapped offset answers
		// with an error so that a stray write shows.
		if (r.bvalid && s_axi_bready)
			next_r.bvalid = 1'b0;
		if (r.aw_got && r.w_got && !r.bvalid)
		begin
			next_r.aw_got = 1'b0;
			next_r.w_got  = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp  = PRS_RESP_OKAY;
			if (r.aw_addr == PRS_CFG_OFFSET)
				next_r.cfg = prs_merge(r.cfg, r.w_data, r.w_strb);
			else if (r.aw_addr == PRS_STEP_OFFSET)
				next_r.step = prs_merge(r.step, r.w_data, r.w_strb);
			else if (r.aw_addr == PRS_STATUS_OFFSET)
				next_r.bresp = PRS_RESP_OKAY;
			else
				next_r.bresp = PRS_RESP_SLVERR;
		end

		// Read channel: one read at a time, answered the next cycle.
		// Status comes from the state before this edge, so it may
		// lag a sample taken in the same cycle.
		if (r.rvalid && s_axi_rready)
			next_r.rvalid = 1'b0;
		if (s_axi_arvalid && !r.rvalid)
		begin
			next_r.rvalid = 1'b1;
			next_r.rresp  = PRS_RESP_OKAY;
			next_r.rdata  = '0;
			if (s_axi_araddr == PRS_CFG_OFFSET)
				next_r.rdata = r.cfg;
			else if (s_axi_araddr == PRS_STEP_OFFSET)
				next_r.rdata = r.step;
			else if (s_axi_araddr == PRS_STATUS_OFFSET)
			begin
				next_r.rdata[PRS_ST_BUSY_BIT] = (r.st != PRS_RS_IDLE);
				next_r.rdata[PRS_ST_MODE_LSB +: 2] = mode;
				next_r.rdata[PRS_ST_COUNT_LSB +: 16] = r.out_count;
			end
			else
				next_r.rresp = PRS_RESP_SLVERR;
		end

		// Re-sampler: each input advances the NCO by one sample; an
		// output falls due when a whole step has elapsed. The residue
		// says how far back the output instant lies and picks the phase.
		case (r.st)
			PRS_RS_IDLE:
				if (in_sample.valid)
				begin
					next_r.hist = {r.hist[PRS_TAPS-2:0], in_sample.data};
					acc = r.nco + PRS_NCO_ONE;
					if (acc >= step_eff)
					begin
						acc = acc - step_eff;
						next_r.phase = PRS_PHASE_W'((PRS_NCO_ONE - 1'b1 - acc)
							>> (PRS_NCO_FRAC - PRS_PHASE_W));
						next_r.mac = '0;
						next_r.tap = '0;
						if (bypass)
						begin
							next_r.rs_data = in_sample.data;
							next_r.st = PRS_RS_OUT;
						end
						else
							next_r.st = PRS_RS_MAC;
					end
					next_r.nco = acc;
				end
			PRS_RS_MAC:
			begin
				// One tap of the selected phase per clock, six in all.
				prod = $signed(prs_proto_coef(int'(r.phase), int'(r.tap)))
					* $signed(r.hist[r.tap]);
				next_r.mac = $signed(r.mac) + prod;
				if (r.tap == PRS_TAP_W'(PRS_TAPS - 1))
				begin
					next_r.rs_data = next_r.mac[PRS_Q +: PRS_DATA_W];
					next_r.st = PRS_RS_OUT;
				end
				else
					next_r.tap = r.tap + 1'b1;
			end
			default:
				if (rs_ready)
					next_r.st = PRS_RS_IDLE;
		endcase

		// Pacing: while interpolating, each sample is handed on no sooner
		// than delay+1 clocks after the last, so the extra data-ready
		// strobes are evenly spread. Spacing below five, or below
		// sixteen for serial output, is too tight for the formatter.
		// Without interpolation the gap is never loaded, so the
		// strobe follows each output as soon as it is ready.
		next_r.out_valid = 1'b0;
		if (pace_src.valid && pace_ready)
		begin
			next_r.out_valid = 1'b1;
			next_r.out_data  = pace_src.data;
			next_r.out_count = r.out_count + 1'b1;
			if (interpolating)
				next_r.gap = r.cfg[PRS_DELAY_LSB +: PRS_DELAY_W];
		end
		else if (r.gap != '0)
			next_r.gap = r.gap - 1'b1;
	end

	// ************************************************************
	// State register
	// ************************************************************
	// The step resets to one, so inputs yield outputs before
	// software has configured anything.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= '{cfg: PRS_CFG_RESET, step: PRS_STEP_RESET, st: PRS_RS_IDLE, default: '0};
		else
			r <= next_r;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Protection bits carry no meaning for this block.
	// Each ready inverts a captured flag, so a second request
	// waits until the first has been answered.
	assign s_axi_awready    = !r.aw_got;
	assign s_axi_wready     = !r.w_got;
	assign s_axi_bvalid     = r.bvalid;
	assign s_axi_bresp      = r.bresp;
	assign s_axi_arready    = !r.rvalid;
	assign s_axi_rvalid     = r.rvalid;
	assign s_axi_rdata      = r.rdata;
	assign s_axi_rresp      = r.rresp;
	assign out_sample.valid = r.out_valid;
	assign out_sample.data  = r.out_data;

endmodule

`default_nettype wire

// ### rtl/prs_pkg.sv
`default_nettype none

package prs_pkg;

	// ************************************************************
	// Widths and register map
	// ************************************************************
	localparam int PRS_DATA_W = 16;
	localparam int PRS_ADDR_W = 8;
	localparam int PRS_Q      = 15;

	localparam logic [PRS_ADDR_W-1:0] PRS_CFG_OFFSET    = 8'h00;
	localparam logic [PRS_ADDR_W-1:0] PRS_STEP_OFFSET   = 8'h04;
	localparam logic [PRS_ADDR_W-1:0] PRS_STATUS_OFFSET = 8'h08;

	localparam logic [31:0] PRS_CFG_RESET  = 32'h0000_0000;
	localparam logic [31:0] PRS_STEP_RESET = 32'h0001_0000;

	localparam logic [1:0] PRS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PRS_RESP_SLVERR = 2'h2;

	// ************************************************************
	// Control word fields
	// ************************************************************
	localparam int PRS_MODE_LSB   = 0;
	localparam int PRS_MODE_W     = 3;
	localparam int PRS_BYPASS_BIT = 3;
	localparam int PRS_DELAY_LSB  = 4;
	localparam int PRS_DELAY_W    = 8;

	localparam int PRS_ST_BUSY_BIT  = 0;
	localparam int PRS_ST_MODE_LSB  = 1;
	localparam int PRS_ST_COUNT_LSB = 16;

	// ************************************************************
	// Filter geometry and numeric control
	// ************************************************************
	localparam int PRS_PHASES       = 32;
	localparam int PRS_TAPS         = 6;
	localparam int PRS_PROTO_LEN    = PRS_PHASES * PRS_TAPS;
	localparam int PRS_PROTO_CENTER = PRS_PROTO_LEN / 2;
	localparam int PRS_PROTO_SCALE  = 113;
	localparam int PRS_PHASE_W      = 5;
	localparam int PRS_TAP_W        = 3;

	localparam int              PRS_NCO_W    = 19;
	localparam int              PRS_NCO_FRAC = 16;
	localparam logic [PRS_NCO_W-1:0] PRS_NCO_ONE = 19'h1_0000;
	localparam logic [PRS_NCO_W-1:0] PRS_NCO_MAX = 19'h4_0000;

	localparam int PRS_HB_LONG_MULS  = 7;
	localparam int PRS_HB_SHORT_MULS = 5;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic                  valid;
		logic [PRS_DATA_W-1:0] data;
	} prs_stream_type;

	typedef enum logic [1:0] {PRS_MODE_RS_ONLY, PRS_MODE_ONE_HB, PRS_MODE_TWO_HB} prs_mode_type;

	typedef enum logic [1:0] {PRS_RS_IDLE, PRS_RS_MAC, PRS_RS_OUT} prs_rs_state_type;

	// ************************************************************
	// Functions
	// ************************************************************
	// Codes other than one and two fall back to the re-sampler alone.
	function automatic prs_mode_type prs_decode_mode(input logic [PRS_MODE_W-1:0] code);
		prs_mode_type m;
		m = PRS_MODE_RS_ONLY;
		if (code == 3'h1)
			m = PRS_MODE_ONE_HB;
		else if (code == 3'h2)
			m = PRS_MODE_TWO_HB;
		return m;
	endfunction

	// Triangular prototype; tap t of phase p sits at index t*32+p.
	function automatic logic [PRS_DATA_W-1:0] prs_proto_coef(input int phase, input int tap);
		int d;
		d = tap * PRS_PHASES + phase - PRS_PROTO_CENTER;
		if (d < 0)
			d = -d;
		return PRS_DATA_W'((PRS_PROTO_CENTER - d) * PRS_PROTO_SCALE);
	endfunction

	// Shared halfband sets, innermost tap first; values are plain defaults.
	function automatic logic [PRS_DATA_W-1:0] prs_hb_coef(input logic long_set, input int k);
		logic [PRS_DATA_W-1:0] c;
		c = 16'h0000;
		if (long_set)
		begin
			case (k)
				0: c = 16'h2870;
				1: c = 16'hf2e0;
				2: c = 16'h0780;
				3: c = 16'hfb80;
				4: c = 16'h0290;
				5: c = 16'hfec0;
				6: c = 16'h0070;
				default: c = 16'h0000;
			endcase
		end
		else
		begin
			case (k)
				0: c = 16'h2800;
				1: c = 16'hf400;
				2: c = 16'h0600;
				3: c = 16'hfd80;
				4: c = 16'h00c0;
				default: c = 16'h0000;
			endcase
		end
		return c;
	endfunction

	// Byte-lane merge for AXI4-Lite writes.
	function automatic logic [31:0] prs_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				v[i*8 +: 8] = wd[i*8 +: 8];
		return v;
	endfunction

endpackage

`default_nettype wire

// ### rtl/prs_halfband_interp.sv
`timescale 1ns/1ps
`default_nettype none

module prs_halfband_interp
	import prs_pkg::*;
#(
	parameter int NMUL     = PRS_HB_LONG_MULS,
	parameter bit LONG_SET = 1'b1
)
(
	// Clock and reset
	input  wire logic           aclk,
	input  wire logic           aresetn,
	// Samples in at the lower rate
	input  wire prs_stream_type in_sample,
	output logic                in_ready,
	// Samples out at twice the rate
	output prs_stream_type      out_sample,
	input  wire logic           out_ready
);

	localparam int HL = 2 * NMUL;
	localparam int CW = $clog2(HL);

	typedef enum logic [1:0] {PRS_HB_IDLE, PRS_HB_MAC, PRS_HB_EVEN, PRS_HB_ODD} prs_hb_state_type;

	typedef struct packed {
		prs_hb_state_type                 st;
		logic [HL-1:0][PRS_DATA_W-1:0]    hist;
		logic [CW-1:0]                    cnt;
		logic [39:0]                      acc;
		logic [PRS_DATA_W-1:0]            data;
	} prs_hb_regs_type;

	prs_hb_regs_type r;
	prs_hb_regs_type next_r;

	// ************************************************************
	// Sequencing
	// ************************************************************
	// The odd output folds symmetric pairs, so a long set costs seven
	// multiplies and a short set five, all on one shared multiplier.
	always_comb
	begin
		logic signed [PRS_DATA_W:0]   pair;
		logic signed [2*PRS_DATA_W+1:0] prod;
		pair   = '0;
		prod   = '0;
		next_r = r;
		case (r.st)
			PRS_HB_IDLE:
				if (in_sample.valid)
				begin
					next_r.hist = {r.hist[HL-2:0], in_sample.data};
					next_r.cnt  = '0;
					next_r.acc  = '0;
					next_r.st   = PRS_HB_MAC;
				end
			PRS_HB_MAC:
			begin
				pair = $signed({r.hist[r.cnt][PRS_DATA_W-1], r.hist[r.cnt]})
					+ $signed({r.hist[CW'(HL-1) - r.cnt][PRS_DATA_W-1],
					r.hist[CW'(HL-1) - r.cnt]});
				prod = $signed(prs_hb_coef(LONG_SET, NMUL - 1 - int'(r.cnt))) * pair;
				next_r.acc = $signed(r.acc) + prod;
				if (r.cnt == CW'(NMUL - 1))
				begin
					next_r.data = r.hist[NMUL-1];
					next_r.st   = PRS_HB_EVEN;
				end
				else
					next_r.cnt = r.cnt + 1'b1;
			end
			PRS_HB_EVEN:
				if (out_ready)
				begin
					next_r.data = r.acc[PRS_Q +: PRS_DATA_W];
					next_r.st   = PRS_HB_ODD;
				end
			default:
				if (out_ready)
					next_r.st = PRS_HB_IDLE;
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= '{st: PRS_HB_IDLE, default: '0};
		else
			r <= next_r;
	end

	// Two outputs per input; the output stalls while downstream is busy.
	assign in_ready         = (r.st == PRS_HB_IDLE);
	assign out_sample.valid = (r.st == PRS_HB_EVEN) || (r.st == PRS_HB_ODD);
	assign out_sample.data  = r.data;

endmodule

`default_nettype wire

// ### test/prs_agc_src.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Upstream gain-stage model
// ************************************************************
module prs_agc_src
	import prs_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Bench request
	input  wire logic        go,
	input  wire logic [15:0] gdata,
	// Stream into the re-sampler
	output prs_stream_type   smp,
	input  wire logic        in_ready
);
	// Hold a sample until taken; scramble the idle data so stale values never pass.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			smp <= '0;
		else if (smp.valid && in_ready)
			smp <= {1'b0, ~smp.data};
		else if (go && !smp.valid)
			smp <= {1'b1, gdata};
	end
endmodule

`default_nettype wire

// ### test/prs_resampler_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Port checker
// ************************************************************
module prs_resampler_chk
	import prs_pkg::*;
(
	// Clock and reset
	input wire logic           aclk,
	input wire logic           aresetn,
	// Register bus
	input wire logic           s_axi_awvalid,
	input wire logic           s_axi_awready,
	input wire logic [7:0]     s_axi_awaddr,
	input wire logic           s_axi_wvalid,
	input wire logic           s_axi_wready,
	input wire logic [31:0]    s_axi_wdata,
	input wire logic           s_axi_bvalid,
	input wire logic           s_axi_bready,
	input wire logic [1:0]     s_axi_bresp,
	input wire logic           s_axi_arvalid,
	input wire logic           s_axi_arready,
	input wire logic           s_axi_rvalid,
	input wire logic           s_axi_rready,
	input wire logic [31:0]    s_axi_rdata,
	// Sample streams
	input wire logic           in_ready,
	input wire prs_stream_type out_sample
);
	logic [31:0] cfg;
	logic [8:0]  gap;
	logic        seen;
	wire logic   interp = (cfg[2:0] == 3'h1) || (cfg[2:0] == 3'h2);

	// Shadow the control word; only full-word writes with both channels together are seen.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg <= PRS_CFG_RESET;
			seen <= 1'b0;
			gap <= 9'h000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
				&& s_axi_awaddr == PRS_CFG_OFFSET)
			begin
				cfg <= s_axi_wdata;
				seen <= 1'b0;
			end
			else if (out_sample.valid)
				seen <= 1'b1;
			gap <= out_sample.valid ? 9'h000 : gap + {8'h00, gap != 9'h1ff};
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	bvalid_holds_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rvalid_holds_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
	read_excl_a: assert property (
		$rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read answered without a request");
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##[0:1] s_axi_bvalid)
		else $error("write not answered in time");
	// Reset clears the data word without a strobe; edges that sample aresetn low are not checked.
	out_hold_a: assert property (
		aresetn && !out_sample.valid |-> $stable(out_sample.data))
		else $error("output data moved without a strobe");
	pulse_gap_a: assert property (
		out_sample.valid && interp && seen |-> gap >= {1'b0, cfg[11:4]})
		else $error("data-ready pulses too close");
	reset_idle_a: assert property (disable iff (1'b0)
		!aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !out_sample.valid && in_ready)
		else $error("outputs not idle in reset");
endmodule

`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Bench top
// ************************************************************
module tb
	import prs_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [15:0] gdata = 16'h0, last_out = 16'h0;
	wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_ready;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	prs_stream_type in_sample, out_sample;
	int fails = 0, checks_done = 0, n_out = 0;

	always #5 aclk = ~aclk;

	prs_resampler dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .in_sample, .in_ready, .out_sample);
	prs_agc_src src (.aclk, .aresetn, .go, .gdata, .smp(in_sample), .in_ready);

	// Formatter side: count strobes and keep the last word.
	always @(posedge aclk)
	begin
		if (out_sample.valid)
		begin
			n_out <= n_out + 1;
			last_out <= out_sample.data;
		end
	end

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic summarize();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit dn;
		dn = 0;
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		for (int k = 0; k < 50 && !dn; k++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				dn = 1;
				s_axi_bready <= 1'b0;
				chk("bresp", s_axi_bresp, er);
			end
		end
		chk("bvalid", dn, 1);
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		bit dn;
		dn = 0;
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		for (int k = 0; k < 50 && !dn; k++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				dn = 1;
				s_axi_rready <= 1'b0;
				chk("rdata", s_axi_rdata, e);
				chk("rresp", s_axi_rresp, er);
			end
		end
		chk("rvalid", dn, 1);
		@(posedge aclk);
	endtask

	// One sample through the upstream model; returns once it has been taken.
	task automatic send(input logic [15:0] d);
		go <= 1'b1;
		gdata <= d;
		@(posedge aclk);
		go <= 1'b0;
		for (int k = 0; k < 400; k++)
		begin
			@(posedge aclk);
			if (!in_sample.valid)
				break;
		end
	endtask

	task automatic drain();
		int q;
		q = 0;
		for (int k = 0; k < 3000 && q < 150; k++)
		begin
			@(posedge aclk);
			q = out_sample.valid ? 0 : q + 1;
		end
	endtask

	task automatic regs_scn();
		rd(PRS_CFG_OFFSET, PRS_CFG_RESET, PRS_RESP_OKAY);
		rd(PRS_STEP_OFFSET, PRS_STEP_RESET, PRS_RESP_OKAY);
		wr(8'h0c, 32'h5, PRS_RESP_SLVERR);
		rd(8'h0c, 32'h0, PRS_RESP_SLVERR);
		wr(PRS_STATUS_OFFSET, 32'hffff_ffff, PRS_RESP_OKAY);
		wr(PRS_CFG_OFFSET, 32'h0000_0ff7, PRS_RESP_OKAY);
		rd(PRS_CFG_OFFSET, 32'h0000_0ff7, PRS_RESP_OKAY);
		rd(PRS_STATUS_OFFSET, 32'h0, PRS_RESP_OKAY);
		wr(PRS_CFG_OFFSET, 32'h0000_0002, PRS_RESP_OKAY);
		rd(PRS_STATUS_OFFSET, 32'h4, PRS_RESP_OKAY);
	endtask

	// Bypassed filter passes the newest input straight to the output.
	task automatic bypass_scn();
		int n0;
		wr(PRS_CFG_OFFSET, 32'h8, PRS_RESP_OKAY);
		wr(PRS_STEP_OFFSET, 32'h1_0000, PRS_RESP_OKAY);
		n0 = n_out;
		for (int i = 0; i < 4; i++)
			send(16'h1234 + 16'(i) * 16'h1111);
		drain();
		chk("bypass count", n_out - n0, 4);
		chk("bypass data", last_out, 16'h4567);
	endtask

	task automatic run_cnt(input logic [31:0] cw, input logic [31:0] st, input int n,
		input int lo, input int hi);
		int c;
		wr(PRS_CFG_OFFSET, cw, PRS_RESP_OKAY);
		wr(PRS_STEP_OFFSET, st, PRS_RESP_OKAY);
		c = n_out;
		for (int i = 0; i < n; i++)
			send(16'h0400 + 16'(i) * 16'h0100);
		drain();
		c = n_out - c;
		chk("output count", (c >= lo && c <= hi), 1);
	endtask

	task automatic reset_scn();
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(PRS_CFG_OFFSET, PRS_CFG_RESET, PRS_RESP_OKAY);
	endtask

	initial
	begin
		#600000;
		fails++;
		summarize();
	end

	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		regs_scn();
		bypass_scn();
		run_cnt(32'h8, 32'h4_0000, 16, 3, 5);
		run_cnt(32'h8, 32'h2_0000, 16, 7, 9);
		run_cnt(32'h8, 32'h1_8000, 12, 7, 9);
		run_cnt(32'h0, 32'h1_0000, 8, 7, 8);
		run_cnt(32'h109, 32'h1_0000, 6, 10, 12);
		run_cnt(32'h5a, 32'h1_0000, 6, 20, 24);
		run_cnt(32'h5d, 32'h1_0000, 6, 5, 6);
		reset_scn();
		summarize();
	end
endmodule

bind prs_resampler prs_resampler_chk chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .in_ready, .out_sample);

`default_nettype wire
